// ### tsr_top.sv
/*
  Timing signal routing top: source muxes for 13 timing signals, function pin
  drivers, trigger line drivers and primary timebase selection.
  Assumes clk at 10 MHz, synchronous active-high rst, pins outside the domain.
*/
// Operation
// - Each of 13 signals has selectable source
// - Conversion strobe sources: triggers, pins, counters
// - All ten function pins reach every selector
// - Several signals may share one pin
// - Per-pin enable drives its assigned signal out
// - Software picks internal or trigger-line timebase
// - Internal timebase may drive a trigger line
// - Startup: internal timebase, no timebase drive
// - At most seven trigger lines used
// - Conversion strobe falls on its pin
`timescale 1ns/1ns

module tsr_top (
  // Clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     rst,
  // Function pins
  input  wire logic [tsr_pkg::NPFI-1:0]                 fpin_in,
  output logic      [tsr_pkg::NPFI-1:0]                 fpin_out,
  output logic      [tsr_pkg::NPFI-1:0]                 fpin_oe,
  // Backplane trigger lines
  input  wire logic [tsr_pkg::NTRIG-1:0]                trig_in,
  output logic      [tsr_pkg::NTRIG-1:0]                trig_out,
  output logic      [tsr_pkg::NTRIG-1:0]                trig_oe,
  // Internal sources
  input  wire logic [tsr_pkg::NSIG-1:0]                 own_sig,
  input  wire logic                                     sample_interval_terminal_count,
  input  wire logic                                     general_counter0_output,
  // Configuration load
  input  wire logic                                     cfg_wr,
  input  wire logic [tsr_pkg::NSIG-1:0][tsr_pkg::SELW-1:0] sel_in,
  input  wire logic [tsr_pkg::NPFI-1:0]                 fpin_en_in,
  input  wire logic [tsr_pkg::NTRIG-1:0]                trig_en_in,
  input  wire logic                                     tb_ext_in,
  input  wire logic                                     tb_drv_in,
  input  wire logic [tsr_pkg::LINEW-1:0]                tb_line_in,
  // Routed timing signals and timebase control
  output logic      [tsr_pkg::NSIG-1:0]                 timing_sig,
  output logic                                          tb_use_external,
  output logic      [tsr_pkg::LINEW-1:0]                tb_line,
  output logic                                          tb_drive_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [tsr_pkg::NEXT-1:0]                    s1;
    logic [tsr_pkg::NEXT-1:0]                    s2;
    logic [tsr_pkg::NEXT-1:0]                    s3;
    logic [tsr_pkg::NEXT-1:0]                    filt;
    logic [tsr_pkg::NSIG-1:0][tsr_pkg::SELW-1:0] sel;
    logic [tsr_pkg::NPFI-1:0]                    fpin_en;
    logic [tsr_pkg::NTRIG-1:0]                   trig_en;
    logic                                        tb_ext;
    logic                                        tb_drv;
    logic [tsr_pkg::LINEW-1:0]                   tb_line;
    logic [tsr_pkg::NSIG-1:0]                    route;
    logic [tsr_pkg::NPFI-1:0]                    fpin_out;
    logic [tsr_pkg::NTRIG-1:0]                   trig_out;
  } tsr_state_s;

  tsr_state_s q;
  tsr_state_s d;
  logic [tsr_pkg::NSIG-1:0] sel_y;
  logic [tsr_pkg::NEXT-1:0] differ;
  logic [tsr_pkg::NTRIG-1:0] tb_mask;

  // ----------------------------------------------------------------
  // Source selectors
  // ----------------------------------------------------------------
  // One mux per signal, all fed from the same filtered pins
  for (genvar i = 0; i < tsr_pkg::NSIG; i++) begin : g_sel
    tsr_src_sel u_sel (
      .trig    (q.filt[tsr_pkg::NTRIG-1:0]),
      .fpin    (q.filt[tsr_pkg::NEXT-1:tsr_pkg::NTRIG]),
      .own_sig (own_sig[i]),
      .sitc    (sample_interval_terminal_count),
      .gc0     (general_counter0_output),
      .sel     (q.sel[i]),
      .y       (sel_y[i])
    );
  end

  // Trigger line driven with the internal timebase is withheld from signal driving
  always_comb begin
    tb_mask = '0;
    if (q.tb_drv && !q.tb_ext) begin
      tb_mask[q.tb_line] = 1'b1;
    end
  end

  assign differ = q.s2 ^ q.s3;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.s1   = {fpin_in, trig_in};
    d.s2   = q.s1;
    d.s3   = q.s2;
    // Accept a level once stages two and three agree
    d.filt = (~differ & q.s2) | (differ & q.filt);
    d.route = sel_y;
    // Each pin carries its own timing signal, strobes inverted
    for (int k = 0; k < tsr_pkg::NPFI; k++) begin
      d.fpin_out[k] = q.route[k] ^ tsr_pkg::FPIN_INV[k];
    end
    for (int k = 0; k < tsr_pkg::NTRIG; k++) begin
      d.trig_out[k] = q.route[k];
    end
    if (cfg_wr) begin
      d.sel     = sel_in;
      d.fpin_en = fpin_en_in;
      d.trig_en = trig_en_in;
      d.tb_ext  = tb_ext_in;
      d.tb_drv  = tb_drv_in;
      d.tb_line = tb_line_in;
    end
    if (rst) begin
      d         = '0;
      for (int i = 0; i < tsr_pkg::NSIG; i++) begin
        d.sel[i] = tsr_pkg::SEL_RST;
      end
      d.fpin_en = tsr_pkg::FPIN_EN_RST;
      // Pins rest at their inactive level, so no false strobe edge at release
      d.fpin_out = tsr_pkg::FPIN_INV;
      d.trig_en = tsr_pkg::TRIG_EN_RST;
      d.tb_ext  = 1'b0;
      d.tb_drv  = 1'b0;
      d.tb_line = tsr_pkg::TB_LINE_RST;
    end
  end

  // Register the whole state
  always_ff @(posedge clk) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign timing_sig      = q.route;
  assign fpin_out        = q.fpin_out;
  assign fpin_oe         = q.fpin_en;
  assign trig_out        = q.trig_out;
  assign trig_oe         = q.trig_en & ~tb_mask;
  assign tb_use_external = q.tb_ext;
  assign tb_line         = q.tb_line;
  assign tb_drive_oe     = q.tb_drv & ~q.tb_ext;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  reset_drivers_off_a: assert property (@(posedge clk)
    rst |=> (fpin_oe == '0) && (trig_oe == '0) && !tb_drive_oe)
    else $error("Drivers on after reset");

  reset_internal_tb_a: assert property (@(posedge clk)
    rst ##1 !cfg_wr [*2] |-> !tb_use_external && !tb_drive_oe)
    else $error("Timebase not internal after reset");

  tb_drive_internal_a: assert property (@(posedge clk) disable iff (rst)
    tb_drive_oe |-> !tb_use_external && !trig_oe[tb_line])
    else $error("Timebase driven while external");

  tb_select_a: assert property (@(posedge clk) disable iff (rst)
    $changed(tb_use_external) && !$past(rst) |->
      $past(cfg_wr) && (tb_use_external == $past(tb_ext_in)))
    else $error("Timebase changed without load");

  pin_enable_a: assert property (@(posedge clk) disable iff (rst)
    cfg_wr ##1 !cfg_wr |-> fpin_oe == $past(fpin_en_in))
    else $error("Pin enable not loaded");

  conv_falls_a: assert property (@(posedge clk) disable iff (rst)
    $rose(timing_sig[tsr_pkg::CONV_IDX]) |=> $fell(fpin_out[tsr_pkg::CONV_IDX]))
    else $error("Conversion strobe did not fall on pin");

  conv_counter_a: assert property (@(posedge clk) disable iff (rst)
    (q.sel[tsr_pkg::CONV_IDX] == tsr_pkg::SRC_SITC) |=>
      timing_sig[tsr_pkg::CONV_IDX] == $past(sample_interval_terminal_count))
    else $error("Conversion strobe not from counter");

  pin_source_a: assert property (@(posedge clk) disable iff (rst)
    (q.sel[0] == tsr_pkg::SRC_FPIN0 + tsr_pkg::SELW'(9)) |=>
      timing_sig[0] == $past(q.filt[tsr_pkg::NEXT-1]))
    else $error("Pin nine not routed");

  shared_pin_a: assert property (@(posedge clk) disable iff (rst)
    (q.sel[0] == q.sel[1]) && (q.sel[0] >= tsr_pkg::SRC_FPIN0) &&
      (q.sel[0] < tsr_pkg::SRC_OWN) |=> timing_sig[0] == timing_sig[1])
    else $error("Shared pin gave different results");

  own_source_a: assert property (@(posedge clk) disable iff (rst)
    (q.sel[12] == tsr_pkg::SRC_OWN) |=> timing_sig[12] == $past(own_sig[12]))
    else $error("Internal source not routed");

  filter_agree_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |->
      (((q.filt ^ $past(q.filt)) & ($past(q.s2) ^ $past(q.s3))) == '0) &&
      (((q.filt ^ $past(q.filt)) & (q.filt ^ $past(q.s2))) == '0))
    else $error("Input accepted before stages agreed");

  conv_pin_cover: cover property (@(posedge clk) disable iff (rst)
    fpin_oe[tsr_pkg::CONV_IDX] && $fell(fpin_out[tsr_pkg::CONV_IDX]));
  tb_drive_cover: cover property (@(posedge clk) disable iff (rst) $rose(tb_drive_oe));
  ext_tb_cover: cover property (@(posedge clk) disable iff (rst) $rose(tb_use_external));
  shared_cover: cover property (@(posedge clk) disable iff (rst)
    (q.sel[0] == tsr_pkg::SRC_FPIN0) && (q.sel[1] == tsr_pkg::SRC_FPIN0));

endmodule // tsr_top

// ### tsr_pkg.sv
/*
  Timing signal routing: shared constants, plus the per-signal source selector.
  Assumes one 10 MHz clock; selector inputs are already synchronised.
*/

// ----------------------------------------------------------------
// Constants
// ----------------------------------------------------------------
package tsr_pkg;
  localparam int unsigned NSIG   = 13;             // Internal timing signals
  localparam int unsigned NPFI   = 10;             // Function pins
  localparam int unsigned NTTL   = 5;              // Backplane TTL trigger lines used
  localparam int unsigned NECL   = 2;              // Backplane ECL trigger lines used
  localparam int unsigned NTRIG  = NTTL + NECL;    // At most seven trigger lines
  localparam int unsigned NEXT   = NTRIG + NPFI;   // Synchronised external inputs
  localparam int unsigned SELW   = 5;
  localparam int unsigned LINEW  = 3;

  typedef logic [SELW-1:0] tsr_sel_t;

  // Source codes: trigger lines, then function pins, then internal sources
  localparam tsr_sel_t SRC_TTL0 = 5'h00;
  localparam tsr_sel_t SRC_ECL0 = 5'h05;
  localparam tsr_sel_t SRC_FPIN0 = 5'h07;
  localparam tsr_sel_t SRC_OWN  = 5'h11;           // Signal's own internal generator
  localparam tsr_sel_t SRC_SITC = 5'h12;           // Sample interval terminal count
  localparam tsr_sel_t SRC_GC0  = 5'h13;           // General counter 0 output
  localparam tsr_sel_t SEL_RST  = SRC_OWN;

  localparam int unsigned CONV_IDX   = 2;          // Conversion strobe index and pin
  localparam int unsigned UPDATE_IDX = 5;          // Output refresh strobe index and pin
  localparam logic [NPFI-1:0]  FPIN_INV    = 10'h024; // Pins driven active low
  localparam logic [NPFI-1:0]  FPIN_EN_RST = 10'h000;
  localparam logic [NTRIG-1:0] TRIG_EN_RST = 7'h00;
  localparam logic [LINEW-1:0] TB_LINE_RST = 3'h0;
endpackage

`timescale 1ns/1ns

// ----------------------------------------------------------------
// Source selector for one timing signal
// ----------------------------------------------------------------
module tsr_src_sel (
  // Candidate sources
  input  wire logic [tsr_pkg::NTRIG-1:0] trig,
  input  wire logic [tsr_pkg::NPFI-1:0]  fpin,
  input  wire logic                      own_sig,
  input  wire logic                      sitc,
  input  wire logic                      gc0,
  // Selection and result
  input  wire tsr_pkg::tsr_sel_t         sel,
  output logic                           y
);
  // Pick one candidate; unknown codes give a quiet low
  always_comb begin
    y = 1'b0;
    if (sel < tsr_pkg::SRC_FPIN0) begin
      y = trig[sel[2:0]];
    end else if (sel < tsr_pkg::SRC_OWN) begin
      y = fpin[4'(sel - tsr_pkg::SRC_FPIN0)];
    end else if (sel == tsr_pkg::SRC_OWN) begin
      y = own_sig;
    end else if (sel == tsr_pkg::SRC_SITC) begin
      y = sitc;
    end else if (sel == tsr_pkg::SRC_GC0) begin
      y = gc0;
    end
  end
endmodule // tsr_src_sel

// ### tsr_far_end.sv
/*
  Far-side model: external circuits and backplane modules driving pins and lines.
  Assumes the bench commands the levels and that the block samples them on clk.
*/
`timescale 1ns/1ns

module tsr_far_end (
  // Clock and commanded levels
  input  wire logic                      clk,
  input  wire logic [tsr_pkg::NPFI-1:0]  fpin_lvl,
  input  wire logic [tsr_pkg::NTRIG-1:0] trig_lvl,
  // Timebase drive from the block
  input  wire logic                      tb_drive_oe,
  input  wire logic [tsr_pkg::LINEW-1:0] tb_line,
  // Levels seen by the block
  output logic      [tsr_pkg::NPFI-1:0]  fpin_in,
  output logic      [tsr_pkg::NTRIG-1:0] trig_in
);
  logic [tsr_pkg::NTRIG-1:0] rel_m;

  // Line handed to the block's timebase is released by us
  always_comb rel_m = tb_drive_oe ? (7'h01 << tb_line) : 7'h00;

  // Levels move after the bench's own update; a released line toggles, never holds
  initial begin
    fpin_in = 10'h000;
    trig_in = 7'h00;
  end
  always @(posedge clk) begin
    #20;
    fpin_in = fpin_lvl;
    trig_in = (trig_lvl & ~rel_m) | (~trig_in & rel_m);
  end
endmodule // tsr_far_end

// ### timing_signal_routing_tb.sv
/*
  Self-checking bench for the timing signal router, with queued expectations.
  Assumes tsr_pkg, tsr_top and tsr_far_end are compiled first.
*/
`timescale 1ns/1ns

module timing_signal_routing_tb;
  typedef struct {int due; int kind; string name; logic [15:0] exp;} tsr_note_s;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, rst, cfg_wr, sitc, gc0, tb_ext_in, tb_drv_in, e;
  logic tb_use_external, tb_drive_oe;
  logic [2:0] tb_line_in, tb_line;
  logic [9:0] fpin_lvl, fpin_in, fpin_out, fpin_oe, fpin_en_in;
  logic [6:0] trig_lvl, trig_in, trig_out, trig_oe, trig_en_in;
  logic [12:0] own_sig, timing_sig;
  logic [12:0][4:0] sel_in;
  int cyc, n_errors, checks, seed;
  tsr_note_s notes[$];
  tsr_note_s n;

  tsr_top u_tsr_top (.clk(clk), .rst(rst), .fpin_in(fpin_in), .fpin_out(fpin_out),
    .fpin_oe(fpin_oe), .trig_in(trig_in), .trig_out(trig_out), .trig_oe(trig_oe),
    .own_sig(own_sig), .sample_interval_terminal_count(sitc),
    .general_counter0_output(gc0), .cfg_wr(cfg_wr), .sel_in(sel_in),
    .fpin_en_in(fpin_en_in), .trig_en_in(trig_en_in), .tb_ext_in(tb_ext_in),
    .tb_drv_in(tb_drv_in), .tb_line_in(tb_line_in), .timing_sig(timing_sig),
    .tb_use_external(tb_use_external), .tb_line(tb_line), .tb_drive_oe(tb_drive_oe));
  tsr_far_end u_tsr_far_end (.clk(clk), .fpin_lvl(fpin_lvl), .trig_lvl(trig_lvl),
    .tb_drive_oe(tb_drive_oe), .tb_line(tb_line), .fpin_in(fpin_in), .trig_in(trig_in));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic hold(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask

  task automatic load();
    cfg_wr = 1'b1;
    hold(1);
    cfg_wr = 1'b0;
  endtask

  task automatic note(input int kind, input string name, input logic [15:0] exp);
    notes.push_back('{cyc, kind, name, exp});
  endtask

  task automatic compare(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [15:0] observe(input int kind);
    case (kind)
      0: return 16'(timing_sig);
      1: return 16'(fpin_out);
      2: return 16'(fpin_oe);
      3: return 16'(trig_oe);
      4: return 16'(trig_out);
      5: return {11'h000, tb_use_external, tb_drive_oe, tb_line};
      6: return {15'h0000, timing_sig[tsr_pkg::CONV_IDX]};
      default: return {15'h0000, fpin_out[tsr_pkg::CONV_IDX]};
    endcase
  endfunction

  // Expected level of one source code for signal i
  function automatic logic exp_src(input logic [4:0] code, input int i);
    if (code < tsr_pkg::SRC_FPIN0) return trig_lvl[code];
    if (code < tsr_pkg::SRC_OWN) return fpin_lvl[code - tsr_pkg::SRC_FPIN0];
    if (code == tsr_pkg::SRC_OWN) return own_sig[i];
    if (code == tsr_pkg::SRC_SITC) return sitc;
    if (code == tsr_pkg::SRC_GC0) return gc0;
    return 1'b0;
  endfunction

  // Monitor: compare each due note against the outputs
  always @(negedge clk) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      n = notes.pop_front();
      compare(n.name, n.exp, observe(n.kind));
    end
  end

  // Cycle count and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(74610);
    {rst, cfg_wr, sitc, gc0, tb_ext_in, tb_drv_in, tb_line_in} = {1'b1, 8'h00};
    {fpin_lvl, trig_lvl, fpin_en_in, trig_en_in, own_sig} = 47'h0;
    sel_in = {13{tsr_pkg::SEL_RST}};
    hold(10);
    rst = 1'b0;
    own_sig = 13'($urandom);
    hold(2);
    note(2, "fpin_oe", 16'h0000);
    note(3, "trig_oe", 16'h0000);
    note(5, "timebase", 16'h0000);
    note(0, "timing_sig", 16'(own_sig));
    // Every source code on the conversion strobe, pins enabled
    {fpin_en_in, trig_en_in} = 17'h1ffff;
    for (int c = 0; c <= 20; c++) begin
      {fpin_lvl, trig_lvl, sitc, gc0} = 19'($urandom);
      sel_in[tsr_pkg::CONV_IDX] = c[4:0];
      load();
      hold(8);
      e = exp_src(c[4:0], tsr_pkg::CONV_IDX);
      note(6, "conv_strobe", {15'h0000, e});
      note(7, "conv_pin", {15'h0000, ~e});
    end
    // All signals share one function pin at a time
    for (int k = 0; k < 10; k++) begin
      fpin_lvl = 10'($urandom);
      for (int i = 0; i < 13; i++) sel_in[i] = tsr_pkg::SRC_FPIN0 + 5'(k);
      load();
      hold(8);
      note(0, "timing_sig", 16'({13{fpin_lvl[k]}}));
      note(1, "fpin_out", 16'({10{fpin_lvl[k]}} ^ tsr_pkg::FPIN_INV));
      note(4, "trig_out", 16'({7{fpin_lvl[k]}}));
    end
    // Timebase choice and drive in all four settings
    for (int m = 0; m < 4; m++) begin
      {tb_drv_in, tb_ext_in} = m[1:0];
      tb_line_in = 3'($urandom_range(6));
      {fpin_en_in, trig_en_in} = 17'($urandom);
      load();
      note(5, "timebase", {11'h000, tb_ext_in, tb_drv_in & ~tb_ext_in, tb_line_in});
      note(3, "trig_oe", 16'(trig_en_in & ~((tb_drv_in & ~tb_ext_in) ?
        (7'h01 << tb_line_in) : 7'h00)));
      note(2, "fpin_oe", 16'(fpin_en_in));
      hold(1);
    end
    // Reset in mid-run beats a load at the same edge
    {tb_drv_in, tb_ext_in, fpin_en_in, trig_en_in} = 19'h7fffd;
    {rst, cfg_wr} = 2'h3;
    hold(1);
    {rst, cfg_wr} = 2'h0;
    note(2, "fpin_oe", 16'h0000);
    note(3, "trig_oe", 16'h0000);
    note(5, "timebase", 16'h0000);
    hold(2);
    test_done();
  end
endmodule // timing_signal_routing_tb
